// ### rtl/gate_pkg.sv
// Constants, types and register map of the fare gate supervisory control.
// Assumes a 50 MHz pclk and an APB master on the station controller side.
//
// Behaviour
// - Refuse second consecutive use, same direction.
// - Refuse time pass reused within passback period.
// - Barred store holds type, start, end.
// - Accept barred updates; at least 100 entries.
// - Arrow and closed never lit together.
// - Special entry flashes arrow 10 s.
// - Top display go, stop, assist, out.
// - Unlatch on media, remote or panic.
// - Close and relatch within 3 s.
// - Panic unlatch sounds local alarm.
// - Alarm when open past set limit.
// - Alarm sounds 10 s or until relatch.
// - Panic during valid opening stays silent.
// - Key switch silences one panic sequence.
// - Emergency variant ignores media and remote.
// - Missing ticket bin forces out of service.
// - Control switch: normal, test, out.
// - Distinct code and message per fault.
// - All present codes shown together.
// - Shutdown on third memory error in 24 h.
package gate_pkg;

  // ==========================================================
  // Timing
  localparam int         CLK_HZ       = 50_000_000;
  localparam int         HALF_SEC_MS  = 500;
  localparam int         FLASH_S      = 10;
  localparam int         CLOSE_S      = 3;
  localparam int         ALARM_S      = 10;
  localparam int         MEM_WIN_H    = 24;
  localparam logic [4:0] FLASH_HALVES = 5'(FLASH_S * 2);
  localparam logic [2:0] CLOSE_HALVES = 3'(CLOSE_S * 2);
  localparam logic [4:0] ALARM_HALVES = 5'(ALARM_S * 2);
  localparam logic [16:0] MEM_WIN_S   = 17'(MEM_WIN_H * 3600);

  // ==========================================================
  // Register map
  localparam logic [7:0] OFS_CFG      = 8'h00;
  localparam logic [7:0] OFS_CMD      = 8'h04;
  localparam logic [7:0] OFS_BAR_LO   = 8'h08;
  localparam logic [7:0] OFS_BAR_HI   = 8'h0c;
  localparam logic [7:0] OFS_BAR_CTL  = 8'h10;
  localparam logic [7:0] OFS_STATUS   = 8'h14;
  localparam logic [7:0] OFS_FAULT    = 8'h18;
  localparam int         CFG_ALM_LSB  = 8;
  localparam int         CFG_EMERG    = 16;
  localparam int         BAR_TYPE_LSB = 24;
  localparam int         BAR_VLD_BIT  = 8;
  localparam logic [2:0] PB_RST       = 3'h6;
  localparam logic [2:0] PB_MIN_STEP  = 3'h1;
  localparam logic [2:0] PB_MAX_STEP  = 3'h6;
  localparam logic [7:0] PB_STEP_MIN  = 8'h05;
  localparam logic [4:0] ALM_RST      = 5'h0a;
  localparam logic [4:0] ALM_LIM_LO   = 5'h0a;
  localparam logic [4:0] ALM_LIM_HI   = 5'h1e;

  // ==========================================================
  // Diagnostics, switch, direction
  localparam int         DG_BIN       = 0;
  localparam int         DG_SWOOS     = 1;
  localparam int         DG_TEST      = 2;
  localparam int         DG_MEM       = 3;
  localparam int         DG_CLOSE     = 4;
  localparam int         DG_EXT       = 5;
  localparam logic [1:0] SW_NORMAL    = 2'h0;
  localparam logic [1:0] SW_TEST      = 2'h1;
  localparam logic       DIR_ENTRY    = 1'b0;

  typedef enum logic [1:0] {G_LATCHED, G_UNLATCH, G_CLOSING} gate_st_t;
  typedef enum logic [2:0] {TOP_IDLE, TOP_GO, TOP_STOP, TOP_ASSIST, TOP_OOS} top_disp_t;

endpackage

// ### rtl/tick_if.sv
// Slow-rate enables passed from the timebase to the supervisor.
// Assumes one clock domain; all signals are one-cycle pulses or levels on pclk.
`timescale 1ns/10ps
interface tick_if;
  logic half_tick;
  logic sec_tick;
  logic flash_ph;
  modport src (output half_tick, sec_tick, flash_ph);
  modport snk (input half_tick, sec_tick, flash_ph);
endinterface

// ### rtl/gate_timebase.sv
// Half-second and one-second enables plus display flash phase.
// Assumes pclk at CLK_HZ; HALF_CYC may be shortened for simulation.
`timescale 1ns/10ps
module gate_timebase
  import gate_pkg::*;
#(
  parameter int HALF_CYC = CLK_HZ / 1000 * HALF_SEC_MS
) (
  input  logic pclk,
  input  logic presetn,
  tick_if.src  tk
);
  logic [31:0] cnt_q;
  logic        half_q;
  logic        sec_q;
  logic        ph_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q  <= 32'h0;
      half_q <= 1'b0;
      sec_q  <= 1'b0;
      ph_q   <= 1'b0;
    end else begin
      half_q <= 1'b0;
      sec_q  <= 1'b0;
      if (cnt_q == 32'(HALF_CYC - 1)) begin
        cnt_q  <= 32'h0;
        half_q <= 1'b1;
        sec_q  <= ph_q;
        ph_q   <= ~ph_q;
      end else begin
        cnt_q <= cnt_q + 32'h1;
      end
    end
  end

  assign tk.half_tick = half_q;
  assign tk.sec_tick  = sec_q;
  assign tk.flash_ph  = ph_q;
endmodule

// ### rtl/fare_gate_supervisory_control.sv
// Fare gate supervisor: passback, barred list, displays, swing gate, diagnostics.
// Assumes APB from the station controller and media results from the transport.
`timescale 1ns/10ps
module fare_gate_supervisory_control
  import gate_pkg::*;
#(
  parameter int HALF_CYC  = CLK_HZ / 1000 * HALF_SEC_MS,
  parameter int BAR_DEPTH = 100
) (
  input  logic        pclk,
  input  logic        presetn,
  input  logic        psel,
  input  logic        penable,
  input  logic        pwrite,
  input  logic [7:0]  paddr,
  input  logic [31:0] pwdata,
  output logic [31:0] prdata_q,
  output logic        pready_q,
  output logic        pslverr_q,
  input  logic        med_valid,
  input  logic        med_dir,
  input  logic        med_ok,
  input  logic [3:0]  med_type,
  input  logic [23:0] med_serial,
  input  logic        med_last_valid,
  input  logic        med_last_dir,
  input  logic        med_timepass,
  input  logic [15:0] med_age_min,
  input  logic        med_special,
  input  logic        med_access,
  input  logic        panic_bar,
  input  logic        key_switch,
  input  logic        gate_open_full,
  input  logic        gate_latched,
  input  logic        bin_present,
  input  logic [1:0]  ctl_switch,
  input  logic [1:0]  ext_fault,
  input  logic        mem_err,
  input  logic        diag_show,
  output logic        res_valid_q,
  output logic        res_accept_q,
  output top_disp_t   top_disp_q,
  output logic        tone_q,
  output logic        end_arrow_q,
  output logic        end_closed_q,
  output logic        unlatch_q,
  output logic        close_drive_q,
  output logic        alarm_q,
  output logic        oos_q,
  output logic        fault_msg_valid_q,
  output logic [3:0]  fault_code_q,
  output logic [7:0]  diag_panel_q
);
  // ==========================================================
  // Timebase
  tick_if tk ();
  gate_timebase #(.HALF_CYC(HALF_CYC)) u_tb (
    .pclk    (pclk),
    .presetn (presetn),
    .tk      (tk.src)
  );

  // ==========================================================
  // APB slave, zero wait, registered answer
  logic [2:0]  pb_steps_q;
  logic [4:0]  alm_lim_q;
  logic        emerg_q;
  logic [23:0] bar_lo_q;
  logic [23:0] bar_hi_q;
  logic [3:0]  bar_type_q;
  logic        shutdown_q;
  logic        close_flt_q;
  logic [7:0]  diag_q;
  logic        wr_en;
  logic        bar_wr;
  logic        cmd_unlatch;
  logic [31:0] rdata;
  logic        rd_err;
  logic [2:0]  new_pb;
  logic [4:0]  new_alm;

  assign wr_en       = psel & penable & pwrite & pready_q;
  assign bar_wr      = wr_en && paddr == OFS_BAR_CTL;
  assign cmd_unlatch = wr_en && paddr == OFS_CMD && pwdata[0];
  assign new_pb      = pwdata[2:0];
  assign new_alm     = pwdata[CFG_ALM_LSB +: 5];

  always_comb begin
    rd_err = 1'b0;
    case (paddr)
      OFS_CFG:     rdata = {15'h0, emerg_q, 3'h0, alm_lim_q, 5'h0, pb_steps_q};
      OFS_BAR_LO:  rdata = {4'h0, bar_type_q, bar_lo_q};
      OFS_BAR_HI:  rdata = {8'h00, bar_hi_q};
      OFS_STATUS:  rdata = {22'h0, shutdown_q, oos_q, diag_q};
      OFS_FAULT:   rdata = {28'h0, fault_code_q};
      OFS_CMD,
      OFS_BAR_CTL: rdata = 32'h0;
      default: begin
        rdata  = 32'h0;
        rd_err = 1'b1;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0;
    end else begin
      pready_q  <= psel & ~penable;
      pslverr_q <= psel & ~penable & rd_err;
      if (psel & ~penable & ~pwrite) begin
        prdata_q <= rdata;
      end
    end
  end

  // Out-of-range fields are dropped, the old value stays
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pb_steps_q <= PB_RST;
      alm_lim_q  <= ALM_RST;
      emerg_q    <= 1'b0;
      bar_lo_q   <= 24'h0;
      bar_hi_q   <= 24'h0;
      bar_type_q <= 4'h0;
    end else if (wr_en) begin
      if (paddr == OFS_CFG) begin
        if (new_pb >= PB_MIN_STEP && new_pb <= PB_MAX_STEP) pb_steps_q <= new_pb;
        if (new_alm >= ALM_LIM_LO && new_alm <= ALM_LIM_HI) alm_lim_q <= new_alm;
        emerg_q <= pwdata[CFG_EMERG];
      end
      if (paddr == OFS_BAR_LO) begin
        bar_lo_q   <= pwdata[23:0];
        bar_type_q <= pwdata[BAR_TYPE_LSB +: 4];
      end
      if (paddr == OFS_BAR_HI) bar_hi_q <= pwdata[23:0];
    end
  end

  // ==========================================================
  // Barred store, one range per entry
  logic [BAR_DEPTH-1:0] bar_hit;

  for (genvar i = 0; i < BAR_DEPTH; i++) begin : g_bar
    logic        vld_q;
    logic [3:0]  typ_q;
    logic [23:0] lo_q;
    logic [23:0] hi_q;
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        vld_q <= 1'b0;
        typ_q <= 4'h0;
        lo_q  <= 24'h0;
        hi_q  <= 24'h0;
      end else if (bar_wr && pwdata[6:0] == 7'(i)) begin
        vld_q <= pwdata[BAR_VLD_BIT];
        typ_q <= bar_type_q;
        lo_q  <= bar_lo_q;
        hi_q  <= bar_hi_q;
      end
    end
    assign bar_hit[i] = vld_q && typ_q == med_type && med_serial >= lo_q
                        && med_serial <= hi_q;
  end

  // ==========================================================
  // Media decision
  logic [7:0] pb_min;
  logic       ref_dir;
  logic       ref_time;
  logic       ref_bar;
  logic       accept;

  assign pb_min   = 8'(pb_steps_q) * PB_STEP_MIN;
  assign ref_dir  = med_last_valid && med_last_dir == med_dir;
  assign ref_time = med_timepass && med_age_min < {8'h00, pb_min};
  assign ref_bar  = |bar_hit;
  assign accept   = ~oos_q & med_ok & ~ref_dir & ~ref_time & ~ref_bar;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_valid_q  <= 1'b0;
      res_accept_q <= 1'b0;
      tone_q       <= 1'b0;
      top_disp_q   <= TOP_IDLE;
    end else begin
      res_valid_q  <= med_valid;
      res_accept_q <= med_valid & accept;
      if (med_valid & ~accept) tone_q <= 1'b1;
      else if (tk.sec_tick) tone_q <= 1'b0;
      if (oos_q) top_disp_q <= TOP_OOS;
      else if (med_valid) begin
        if (accept) top_disp_q <= TOP_GO;
        else if (ref_dir | ref_time | ref_bar) top_disp_q <= TOP_ASSIST;
        else top_disp_q <= TOP_STOP;
      end else if (top_disp_q == TOP_OOS) top_disp_q <= TOP_IDLE;
    end
  end

  // ==========================================================
  // End displays
  logic [4:0] flash_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_q      <= 5'h0;
      end_arrow_q  <= 1'b0;
      end_closed_q <= 1'b1;
    end else begin
      if (med_valid & accept) begin
        flash_q <= (med_special && med_dir == DIR_ENTRY) ? FLASH_HALVES : 5'h0;
      end else if (tk.half_tick && flash_q != 5'h0) begin
        flash_q <= flash_q - 5'h1;
      end
      end_arrow_q  <= ~oos_q & (flash_q == 5'h0 | tk.flash_ph);
      end_closed_q <= oos_q;
    end
  end

  // ==========================================================
  // Swing gate and local alarm
  gate_st_t   gst_q;
  logic       valid_open_q;
  logic       key_arm_q;
  logic       key_prev_q;
  logic       alm_done_q;
  logic [2:0] close_cnt_q;
  logic [4:0] open_s_q;
  logic [4:0] alm_cnt_q;
  logic       cause_any;
  logic       panic_go;
  logic       relatch;
  logic       key_rise;
  logic       alm_start;

  assign cause_any = ~emerg_q & ((med_valid & accept & med_access) | cmd_unlatch);
  assign panic_go  = gst_q == G_LATCHED && panic_bar && !cause_any;
  assign relatch   = gst_q == G_CLOSING && gate_latched;
  assign key_rise  = key_switch & ~key_prev_q;
  assign alm_start = (panic_go & ~key_arm_q)
                   | (valid_open_q && gst_q != G_LATCHED && !alm_done_q
                      && open_s_q > alm_lim_q);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gst_q         <= G_LATCHED;
      unlatch_q     <= 1'b0;
      close_drive_q <= 1'b0;
      valid_open_q  <= 1'b0;
    end else begin
      case (gst_q)
        G_LATCHED: if (cause_any | panic_bar) begin
          gst_q        <= G_UNLATCH;
          unlatch_q    <= 1'b1;
          valid_open_q <= cause_any;
        end
        G_UNLATCH: if (gate_open_full) begin
          gst_q         <= G_CLOSING;
          unlatch_q     <= 1'b0;
          close_drive_q <= 1'b1;
        end
        G_CLOSING: if (gate_latched) begin
          gst_q         <= G_LATCHED;
          close_drive_q <= 1'b0;
          valid_open_q  <= 1'b0;
        end
        default: gst_q <= G_LATCHED;
      endcase
    end
  end

  // Closing watchdog; a slow relatch is reported as a fault
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      close_cnt_q <= 3'h0;
      close_flt_q <= 1'b0;
    end else if (gst_q != G_CLOSING || gate_latched) begin
      close_cnt_q <= 3'h0;
      close_flt_q <= 1'b0;
    end else if (tk.half_tick) begin
      if (close_cnt_q == CLOSE_HALVES) close_flt_q <= 1'b1;
      else close_cnt_q <= close_cnt_q + 3'h1;
    end
  end

  // Key arms one silent panic sequence; a new turn wins over consumption
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_prev_q <= 1'b0;
      key_arm_q  <= 1'b0;
    end else begin
      key_prev_q <= key_switch;
      key_arm_q  <= key_rise | (key_arm_q & ~(panic_go & ~cause_any));
    end
  end

  // Panic while open is ignored by the state machine, so no alarm
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm_q    <= 1'b0;
      alm_cnt_q  <= 5'h0;
      alm_done_q <= 1'b0;
      open_s_q   <= 5'h0;
    end else begin
      if (gst_q == G_LATCHED) begin
        open_s_q   <= 5'h0;
        alm_done_q <= 1'b0;
      end else if (tk.sec_tick && open_s_q != 5'h1f) begin
        open_s_q <= open_s_q + 5'h1;
      end
      if (alm_start) begin
        alarm_q    <= 1'b1;
        alm_cnt_q  <= 5'h0;
        alm_done_q <= 1'b1;
      end else if (alarm_q) begin
        if (relatch || alm_cnt_q == ALARM_HALVES) alarm_q <= 1'b0;
        else if (tk.half_tick) alm_cnt_q <= alm_cnt_q + 5'h1;
      end
    end
  end

  // ==========================================================
  // Memory error window
  logic [16:0] mem_age_q [2];
  logic [1:0]  mem_v_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_v_q    <= 2'h0;
      shutdown_q <= 1'b0;
      for (int i = 0; i < 2; i++) mem_age_q[i] <= 17'h0;
    end else if (mem_err) begin
      shutdown_q   <= shutdown_q | (&mem_v_q);
      mem_v_q      <= {mem_v_q[0], 1'b1};
      mem_age_q[1] <= mem_age_q[0];
      mem_age_q[0] <= 17'h0;
    end else if (tk.sec_tick) begin
      for (int i = 0; i < 2; i++) begin
        if (mem_age_q[i] == MEM_WIN_S - 17'h1) mem_v_q[i] <= 1'b0;
        else mem_age_q[i] <= mem_age_q[i] + 17'h1;
      end
    end
  end

  // ==========================================================
  // Diagnostics and fault messages
  logic [7:0] diag_now;
  logic [7:0] pend_q;
  logic [7:0] sent;
  logic [3:0] code;

  assign diag_now = {1'b0, ext_fault, close_flt_q, shutdown_q,
                     ctl_switch == SW_TEST,
                     ctl_switch != SW_NORMAL && ctl_switch != SW_TEST,
                     ~bin_present};

  always_comb begin
    sent = 8'h0;
    code = 4'h0;
    for (int i = 7; i >= 0; i--) begin
      if (pend_q[i]) begin
        sent = 8'h1 << i;
        code = 4'(i + 1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      diag_q            <= 8'h0;
      pend_q            <= 8'h0;
      oos_q             <= 1'b1;
      fault_msg_valid_q <= 1'b0;
      fault_code_q      <= 4'h0;
      diag_panel_q      <= 8'h0;
    end else begin
      diag_q            <= diag_now;
      oos_q             <= |diag_now;
      pend_q            <= (pend_q & ~sent) | (diag_now & ~diag_q);
      fault_msg_valid_q <= |pend_q;
      if (|pend_q) fault_code_q <= code;
      diag_panel_q      <= diag_show ? diag_q : 8'h0;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_panic_unlatch;
    panic_go && !key_arm_q;
  endsequence
  sequence s_alarm_up;
    alarm_q && gst_q == G_UNLATCH;
  endsequence

  chk_dir_refuse: assert property (
    med_valid && med_last_valid && med_last_dir == med_dir |=> res_valid_q && !res_accept_q)
    else $error("repeat direction accepted");
  chk_time_refuse: assert property (
    med_valid && med_timepass && med_age_min < 16'(pb_steps_q) * 16'h5 |=> !res_accept_q)
    else $error("passback period not enforced");
  chk_barred_refuse: assert property (
    med_valid && ref_bar |=> !res_accept_q && top_disp_q != TOP_GO)
    else $error("barred medium accepted");
  chk_end_exclusive: assert property (!(end_arrow_q && end_closed_q))
    else $error("arrow and closed lit together");
  chk_flash_clear: assert property (
    med_valid && accept && !med_special |=> flash_q == 5'h0)
    else $error("flash not cleared on release");
  chk_stop_tone: assert property (
    med_valid && !accept |=> tone_q && top_disp_q != TOP_GO)
    else $error("refusal without tone");
  chk_emerg_media: assert property (
    emerg_q && gst_q == G_LATCHED && !panic_bar |=> gst_q == G_LATCHED)
    else $error("emergency gate unlatched without panic");
  chk_panic_alarm: assert property (s_panic_unlatch |=> s_alarm_up)
    else $error("panic unlatch silent");
  chk_key_silent: assert property (
    panic_go && key_arm_q && !alarm_q |=> !alarm_q)
    else $error("keyed panic sounded");
  chk_alarm_relatch: assert property (alarm_q && relatch |=> !alarm_q)
    else $error("alarm held after relatch");
  chk_bin_oos: assert property (!bin_present |=> oos_q ##1 end_closed_q)
    else $error("no bin yet in service");
  chk_mem_third: assert property (mem_err && &mem_v_q |=> shutdown_q)
    else $error("third memory error ignored");
  chk_cfg_range: assert property (pb_steps_q inside {[1:6]} && alm_lim_q inside {[10:30]})
    else $error("parameter out of range");
endmodule

// ### sim/station_ctrl_model.sv
// Station fare controller model: APB master downloading parameters and barred list.
// Assumes the bench calls xfer; one transfer at a time.
`timescale 1ns/10ps
module station_ctrl_model (
  input  logic        pclk,
  input  logic        pready_q,
  input  logic        pslverr_q,
  input  logic [31:0] prdata_q,
  output logic        psel,
  output logic        penable,
  output logic        pwrite,
  output logic [7:0]  paddr,
  output logic [31:0] pwdata,
  output logic        tmo
);
  // ==========================================================
  // Single controller; passback state travels on the medium
  initial begin
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
    tmo = 0;
  end

  // Setup, then access held until pready sampled high or 20 cycles pass
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    int n;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do @(posedge pclk); while (pready_q !== 1'b1 && ++n < 20);
    if (n >= 20) tmo = 1;
    rd = prdata_q;
    err = pslverr_q;
    psel <= 0;
    penable <= 0;
    pwdata <= ~d;
  endtask
endmodule

// ### sim/fare_gate_supervisory_control_tb.sv
// Self-checking bench for the fare gate supervisor.
// Assumes a shortened half-second tick; APB driven through the controller model.
`timescale 1ns/10ps
module fare_gate_supervisory_control_tb
  import gate_pkg::*;
;
  logic pclk, psel, penable, pwrite, pready_q, pslverr_q, tmo, res_valid_q, res_accept_q;
  logic [7:0] paddr, diag_panel_q;
  logic [31:0] pwdata, prdata_q, rdv;
  logic presetn = 0, med_valid = 0, med_dir = 0, med_ok = 1, med_last_valid = 0;
  logic med_last_dir = 0, med_timepass = 0, med_special = 0, med_access = 0, err;
  logic [3:0] med_type = 0, fault_code_q;
  logic [23:0] med_serial = 0;
  logic [15:0] med_age_min = 0;
  logic panic_bar = 0, key_switch = 0, gate_open_full = 0, gate_latched = 1;
  logic bin_present = 1, mem_err = 0, diag_show = 0;
  logic [1:0] ctl_switch = SW_NORMAL, ext_fault = 0;
  top_disp_t top_disp_q;
  logic tone_q, end_arrow_q, end_closed_q, unlatch_q, close_drive_q, alarm_q, oos_q;
  logic fault_msg_valid_q;
  int fail_count = 0, n_tests = 0;

  fare_gate_supervisory_control #(.HALF_CYC(10)) uut (.*);
  station_ctrl_model ctrl (.*);

  initial begin
    pclk = 0;
    forever #10 pclk = ~pclk;
  end

  // ==========================================================
  // Tasks
  task automatic end_of_test();
    if (fail_count == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ctrl.xfer(1, a, d, rdv, err);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic ee);
    ctrl.xfer(0, a, 32'h0, rdv, err);
    chk(rdv, e);
    chk(err, ee);
  endtask

  task automatic med(input logic d, lv, tp, input logic [15:0] age,
                     input logic [3:0] ty, input logic [23:0] sn, input top_disp_t ex);
    @(posedge pclk);
    med_valid <= 1;
    med_dir <= d;
    med_last_valid <= lv;
    med_last_dir <= 0;
    med_timepass <= tp;
    med_age_min <= age;
    med_type <= ty;
    med_serial <= sn;
    @(posedge pclk);
    med_valid <= 0;
    #1;
    chk(res_valid_q, 1);
    chk(res_accept_q, ex == TOP_GO);
    chk(top_disp_q, ex);
    chk(end_arrow_q & end_closed_q, 0);
  endtask

  // Counts lit arrow samples over a number of cycles
  task automatic arrow_cnt(input int cyc, input int e);
    int n;
    n = 0;
    repeat (cyc) begin
      @(posedge pclk);
      #1;
      n += end_arrow_q;
    end
    chk(n, e);
  endtask

  // Trigger 0 panic, 1 remote, 2 media; hold keeps it unlatched with panic pressed
  task automatic gate_cycle(input logic [1:0] how, input logic eu, ea, input int hold);
    if (how == 2'h1) wr(OFS_CMD, 32'h1);
    else if (how == 2'h2) med(0, 0, 0, 0, 1, 24'h000005, TOP_GO);
    else begin
      @(posedge pclk);
      panic_bar <= 1;
      @(posedge pclk);
      panic_bar <= 0;
    end
    repeat (2) @(posedge pclk);
    #1;
    chk(unlatch_q, eu);
    chk(alarm_q, ea);
    if (eu) begin
      @(posedge pclk);
      if (hold > 0) begin
        panic_bar <= 1;
        repeat (hold) @(posedge pclk);
        panic_bar <= 0;
      end
      gate_latched <= 0;
      gate_open_full <= 1;
      repeat (2) @(posedge pclk);
      #1;
      chk(close_drive_q, 1);
      chk(alarm_q, ea || hold > 220);
      @(posedge pclk);
      gate_open_full <= 0;
      gate_latched <= 1;
      repeat (2) @(posedge pclk);
      #1;
      chk(alarm_q, 0);
      chk(close_drive_q, 0);
    end
    @(posedge pclk);
  endtask

  initial begin
    repeat (100000) @(posedge pclk);
    fail_count++;
    end_of_test();
  end

  // ==========================================================
  // Main sequence
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1;
    repeat (4) @(posedge pclk);
    chk(oos_q, 0);
    rd_chk(OFS_CFG, 32'h00000a06, 0);
    wr(OFS_CFG, 32'h00000a03);
    wr(OFS_CFG, 32'h00000a07);
    rd_chk(OFS_CFG, 32'h00000a03, 0);
    rd_chk(8'h1c, 32'h0, 1);
    wr(OFS_BAR_LO, 32'h02000100);
    wr(OFS_BAR_HI, 32'h00000110);
    wr(OFS_BAR_CTL, 32'h00000100);
    med(0, 0, 0, 0, 2, 24'h000110, TOP_ASSIST);
    med(0, 0, 0, 0, 2, 24'h000111, TOP_GO);
    med(0, 0, 0, 0, 3, 24'h000105, TOP_GO);
    med(0, 1, 0, 0, 1, 24'h000005, TOP_ASSIST);
    med(1, 1, 0, 0, 1, 24'h000005, TOP_GO);
    med(0, 0, 1, 14, 1, 24'h000005, TOP_ASSIST);
    med(0, 0, 1, 15, 1, 24'h000005, TOP_GO);
    @(posedge pclk);
    med_ok <= 0;
    med(0, 0, 0, 0, 1, 24'h000005, TOP_STOP);
    chk(tone_q, 1);
    @(posedge pclk);
    med_ok <= 1;
    med_special <= 1;
    med(0, 0, 0, 0, 1, 24'h000005, TOP_GO);
    arrow_cnt(40, 20);
    repeat (170) @(posedge pclk);
    arrow_cnt(40, 40);
    med(0, 0, 0, 0, 1, 24'h000005, TOP_GO);
    med(1, 0, 0, 0, 1, 24'h000005, TOP_GO);
    arrow_cnt(20, 20);
    gate_cycle(0, 1, 1, 0);
    key_switch <= 1;
    gate_cycle(0, 1, 0, 0);
    key_switch <= 0;
    gate_cycle(0, 1, 1, 0);
    gate_cycle(1, 1, 0, 150);
    gate_cycle(1, 1, 0, 240);
    med_access <= 1;
    gate_cycle(2, 1, 0, 0);
    wr(OFS_CFG, 32'h00010a03);
    gate_cycle(1, 0, 0, 0);
    gate_cycle(2, 0, 0, 0);
    bin_present <= 0;
    ctl_switch <= 2'h2;
    diag_show <= 1;
    repeat (3) @(posedge pclk);
    #1;
    chk(oos_q, 1);
    chk({end_closed_q, end_arrow_q}, 2'b10);
    chk(diag_panel_q, 8'h03);
    chk(fault_msg_valid_q, 1);
    chk(fault_code_q, 4'h2);
    rd_chk(OFS_STATUS, 32'h00000103, 0);
    rd_chk(OFS_FAULT, 32'h2, 0);
    bin_present <= 1;
    ctl_switch <= SW_NORMAL;
    diag_show <= 0;
    for (int i = 0; i < 3; i++) begin
      @(posedge pclk);
      mem_err <= 1;
      @(posedge pclk);
      mem_err <= 0;
      repeat (4) @(posedge pclk);
      #1;
      chk(oos_q, i == 2);
    end
    chk(tmo, 0);
    end_of_test();
  end
endmodule
